// ===== core/current_fault_response_ctrl.sv
// per-page overcurrent and undercurrent fault response controller
`timescale 1ns/10ps
module current_fault_response_ctrl #(
    parameter int PAGES = fault_resp_pkg::PAGES_DEFAULT,
    parameter int RETRY_UNIT_CYCLES = fault_resp_pkg::RETRY_UNIT_CYCLES
) (
    input wire logic clock, // system clock, 100 MHz
    input wire logic srst, // synchronous reset, active high
    input wire logic link_clock, // command link clock
    input wire logic link_srst, // link reset, synchronous to link_clock
    input wire logic cmd_start, // command request pulse, link domain
    input wire logic cmd_write, // 1 write, 0 read
    input wire logic [7:0] cmd_code, // command code
    input wire logic [7:0] cmd_wdata, // write data
    output logic cmd_busy, // command in flight
    output logic rsp_done, // command finished pulse
    output logic [7:0] rsp_rdata, // read data
    output logic rsp_error, // unsupported command or value
    input wire logic [PAGES-1:0] oc_fault_pin, // overcurrent detected, per page
    input wire logic [PAGES-1:0] uc_fault_pin, // undercurrent detected, per page
    input wire logic [PAGES-1:0] off_cmd, // output commanded off, per page
    input wire logic bias_ok, // bias power good
    output logic [PAGES-1:0] output_enable, // output allowed on, per page
    output logic [PAGES-1:0] turn_on_start, // start turn-on sequence pulse
    output logic [PAGES*8-1:0] status_iout, // status byte per page
    output logic alert_pin_n_out, // alert pin drive level
    output logic alert_pin_n_oe // alert pin pulled low while high
);
    localparam int PW = (PAGES > 1) ? $clog2(PAGES) : 1;
    localparam int PRE_W = $clog2(RETRY_UNIT_CYCLES + 1);
    localparam int SL = fault_resp_pkg::SYNC_STAGES - 1;
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(RETRY_UNIT_CYCLES - 1);
    localparam logic [7:0] PAGE_LIMIT = 8'(PAGES);

    // =====================================================================
    // link side of the command handshake
    logic req_tog_reg;
    logic [7:0] lk_code_reg;
    logic [7:0] lk_wdata_reg;
    logic lk_write_reg;
    logic [SL:0] ack_sync_reg;
    logic ack_seen_reg;
    logic ack_changed;
    logic ack_tog_reg;
    logic [7:0] core_rdata_reg;
    logic core_err_reg;

    assign ack_changed = (ack_sync_reg[SL] == ack_sync_reg[SL-1]) && (ack_sync_reg[SL] != ack_seen_reg);

    always_ff @(posedge link_clock) begin
        if (link_srst) begin
            ack_sync_reg <= '0;
            ack_seen_reg <= 1'b0;
        end else begin
            ack_sync_reg <= {ack_sync_reg[SL-1:0], ack_tog_reg};
            if (ack_changed) begin
                ack_seen_reg <= ack_sync_reg[SL];
            end
        end
    end

    always_ff @(posedge link_clock) begin
        if (link_srst) begin
            req_tog_reg <= 1'b0;
            cmd_busy <= 1'b0;
            lk_code_reg <= 8'h00;
            lk_wdata_reg <= 8'h00;
            lk_write_reg <= 1'b0;
        end else if (cmd_start && !cmd_busy) begin
            req_tog_reg <= !req_tog_reg;
            cmd_busy <= 1'b1;
            lk_code_reg <= cmd_code;
            lk_wdata_reg <= cmd_wdata;
            lk_write_reg <= cmd_write;
        end else if (ack_changed) begin
            cmd_busy <= 1'b0;
        end
    end

    // answer words are held stable by the core until the next request
    always_ff @(posedge link_clock) begin
        if (link_srst) begin
            rsp_done <= 1'b0;
            rsp_rdata <= 8'h00;
            rsp_error <= 1'b0;
        end else begin
            rsp_done <= ack_changed;
            if (ack_changed) begin
                rsp_rdata <= core_rdata_reg;
                rsp_error <= core_err_reg;
            end
        end
    end

    // =====================================================================
    // core side of the command handshake
    logic [SL:0] req_sync_reg;
    logic req_seen_reg;
    logic exec;
    logic exec_write;
    logic clear_pulse_reg;
    logic [PW-1:0] page_reg;
    logic [7:0] oc_action_reg [PAGES];
    logic [7:0] uc_action_reg [PAGES];
    logic [PAGES-1:0] oc_stat_reg;
    logic [PAGES-1:0] uc_stat_reg;

    assign exec = (req_sync_reg[SL] == req_sync_reg[SL-1]) && (req_sync_reg[SL] != req_seen_reg);
    assign exec_write = exec && lk_write_reg;

    always_ff @(posedge clock) begin
        if (srst) begin
            req_sync_reg <= '0;
            req_seen_reg <= 1'b0;
        end else begin
            req_sync_reg <= {req_sync_reg[SL-1:0], req_tog_reg};
            if (exec) begin
                req_seen_reg <= req_sync_reg[SL];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ack_tog_reg <= 1'b0;
            core_rdata_reg <= 8'h00;
            core_err_reg <= 1'b0;
        end else if (exec) begin
            ack_tog_reg <= !ack_tog_reg;
            core_err_reg <= 1'b0;
            core_rdata_reg <= 8'h00;
            unique case (lk_code_reg)
                fault_resp_pkg::CODE_PAGE: begin
                    core_rdata_reg <= 8'(page_reg);
                    core_err_reg <= lk_write_reg && lk_wdata_reg >= PAGE_LIMIT;
                end
                fault_resp_pkg::CODE_OC_ACTION: begin
                    core_rdata_reg <= oc_action_reg[page_reg];
                end
                fault_resp_pkg::CODE_UC_ACTION: begin
                    core_rdata_reg <= uc_action_reg[page_reg];
                end
                fault_resp_pkg::CODE_STATUS_IOUT: begin
                    core_rdata_reg <= status_iout[8*page_reg +: 8];
                    core_err_reg <= lk_write_reg;
                end
                fault_resp_pkg::CODE_CLEAR_FAULTS: begin
                    core_err_reg <= !lk_write_reg;
                end
                default: begin
                    core_err_reg <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            page_reg <= '0;
        end else if (exec_write && lk_code_reg == fault_resp_pkg::CODE_PAGE && lk_wdata_reg < PAGE_LIMIT) begin
            page_reg <= lk_wdata_reg[PW-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            clear_pulse_reg <= 1'b0;
        end else begin
            clear_pulse_reg <= exec_write && lk_code_reg == fault_resp_pkg::CODE_CLEAR_FAULTS;
        end
    end

    // =====================================================================
    // retry time base
    logic [PRE_W-1:0] pre_count_reg;
    logic tick_reg;

    always_ff @(posedge clock) begin
        if (srst || pre_count_reg == PRE_LAST) begin
            pre_count_reg <= '0;
        end else begin
            pre_count_reg <= pre_count_reg + PRE_W'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= pre_count_reg == PRE_LAST;
        end
    end

    // =====================================================================
    // per page: configuration, fault inputs, engines, status
    logic [PAGES-1:0] oc_level;
    logic [PAGES-1:0] uc_level;
    logic [PAGES-1:0] oc_rise;
    logic [PAGES-1:0] uc_rise;
    logic [PAGES-1:0] oc_disable;
    logic [PAGES-1:0] uc_disable;
    logic [PAGES-1:0] oc_restart;
    logic [PAGES-1:0] uc_restart;

    genvar p;
    generate
        for (p = 0; p < PAGES; p++) begin : g_page
            logic [SL:0] oc_sync_reg;
            logic [SL:0] uc_sync_reg;
            logic oc_filt_reg;
            logic uc_filt_reg;
            logic oc_prev_reg;
            logic uc_prev_reg;

            always_ff @(posedge clock) begin
                if (srst) begin
                    oc_action_reg[p] <= fault_resp_pkg::ACTION_RESET;
                    uc_action_reg[p] <= fault_resp_pkg::ACTION_RESET;
                end else if (exec_write && page_reg == PW'(p)) begin
                    if (lk_code_reg == fault_resp_pkg::CODE_OC_ACTION) begin
                        oc_action_reg[p] <= lk_wdata_reg;
                    end
                    if (lk_code_reg == fault_resp_pkg::CODE_UC_ACTION) begin
                        uc_action_reg[p] <= lk_wdata_reg;
                    end
                end
            end

            // a level counts once the last two stages agree
            always_ff @(posedge clock) begin
                if (srst) begin
                    oc_sync_reg <= '0;
                    uc_sync_reg <= '0;
                    oc_filt_reg <= 1'b0;
                    uc_filt_reg <= 1'b0;
                    oc_prev_reg <= 1'b0;
                    uc_prev_reg <= 1'b0;
                end else begin
                    oc_sync_reg <= {oc_sync_reg[SL-1:0], oc_fault_pin[p]};
                    uc_sync_reg <= {uc_sync_reg[SL-1:0], uc_fault_pin[p]};
                    if (oc_sync_reg[SL] == oc_sync_reg[SL-1]) begin
                        oc_filt_reg <= oc_sync_reg[SL];
                    end
                    if (uc_sync_reg[SL] == uc_sync_reg[SL-1]) begin
                        uc_filt_reg <= uc_sync_reg[SL];
                    end
                    oc_prev_reg <= oc_filt_reg;
                    uc_prev_reg <= uc_filt_reg;
                end
            end

            assign oc_level[p] = oc_filt_reg;
            assign uc_level[p] = uc_filt_reg;
            assign oc_rise[p] = oc_filt_reg && !oc_prev_reg;
            assign uc_rise[p] = uc_filt_reg && !uc_prev_reg;

            // a new fault in the clearing cycle wins over the clear
            always_ff @(posedge clock) begin
                if (srst) begin
                    oc_stat_reg[p] <= 1'b0;
                    uc_stat_reg[p] <= 1'b0;
                end else begin
                    if (oc_rise[p]) begin
                        oc_stat_reg[p] <= 1'b1;
                    end else if (clear_pulse_reg) begin
                        oc_stat_reg[p] <= 1'b0;
                    end
                    if (uc_rise[p]) begin
                        uc_stat_reg[p] <= 1'b1;
                    end else if (clear_pulse_reg) begin
                        uc_stat_reg[p] <= 1'b0;
                    end
                end
            end

            // one fault shutting the page down stops the other's retries
            fault_engine u_oc_engine (
                .clock(clock),
                .srst(srst),
                .tick(tick_reg),
                .fault_level(oc_level[p]),
                .action(oc_action_reg[p]),
                .stop_retry(off_cmd[p] || !bias_ok || uc_disable[p]),
                .clear_faults(clear_pulse_reg),
                .disable_reg(oc_disable[p]),
                .restart_reg(oc_restart[p])
            );

            fault_engine u_uc_engine (
                .clock(clock),
                .srst(srst),
                .tick(tick_reg),
                .fault_level(uc_level[p]),
                .action(uc_action_reg[p]),
                .stop_retry(off_cmd[p] || !bias_ok || oc_disable[p]),
                .clear_faults(clear_pulse_reg),
                .disable_reg(uc_disable[p]),
                .restart_reg(uc_restart[p])
            );

            always_ff @(posedge clock) begin
                if (srst) begin
                    status_iout[8*p +: 8] <= 8'h00;
                    output_enable[p] <= 1'b0;
                    turn_on_start[p] <= 1'b0;
                end else begin
                    status_iout[8*p +: 8] <= 8'h00;
                    status_iout[8*p + fault_resp_pkg::STATUS_OC_BIT] <= oc_stat_reg[p];
                    status_iout[8*p + fault_resp_pkg::STATUS_UC_BIT] <= uc_stat_reg[p];
                    output_enable[p] <= !(oc_disable[p] || uc_disable[p] || off_cmd[p]);
                    turn_on_start[p] <= (oc_restart[p] || uc_restart[p]) && !off_cmd[p]
                        && !(oc_disable[p] && uc_disable[p]);
                end
            end
        end
    endgenerate

    // =====================================================================
    // alert pin, open drain, held low while any fault bit stands
    always_ff @(posedge clock) begin
        if (srst) begin
            alert_pin_n_out <= 1'b0;
            alert_pin_n_oe <= 1'b0;
        end else begin
            alert_pin_n_out <= 1'b0;
            alert_pin_n_oe <= (|oc_stat_reg) || (|uc_stat_reg);
        end
    end

    // =====================================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    sequence s_oc_write_p0;
        exec_write && lk_code_reg == fault_resp_pkg::CODE_OC_ACTION && page_reg == '0;
    endsequence

    sequence s_fault_to_alert;
        oc_rise[0] ##1 oc_stat_reg[0] ##1 alert_pin_n_oe;
    endsequence

    chk_action_reset: assert property ($past(srst) |-> oc_action_reg[0] == fault_resp_pkg::ACTION_RESET
        && uc_action_reg[0] == fault_resp_pkg::ACTION_RESET)
        else $error("action byte wrong after reset");
    chk_action_write: assert property (s_oc_write_p0 |=> oc_action_reg[0] == $past(lk_wdata_reg))
        else $error("action byte not stored for page");
    chk_alert_path: assert property (oc_rise[0] |-> s_fault_to_alert)
        else $error("fault did not pull alert low");
    chk_status_sticky: assert property (oc_stat_reg[0] && !clear_pulse_reg |=> oc_stat_reg[0])
        else $error("status bit dropped without clear");
    chk_uc_status: assert property (uc_rise[0] |=> uc_stat_reg[0]
        ##1 status_iout[fault_resp_pkg::STATUS_UC_BIT])
        else $error("undercurrent status bit not set");
    chk_oc_status: assert property (oc_rise[0] |=> ##1 status_iout[fault_resp_pkg::STATUS_OC_BIT])
        else $error("overcurrent status bit not set");
    chk_tick_spacing: assert property (tick_reg |=> !tick_reg)
        else $error("retry time base ticked twice in a row");
    chk_page_private: assert property (exec_write && page_reg != '0 |=> oc_action_reg[0] == $past(oc_action_reg[0])
        && uc_action_reg[0] == $past(uc_action_reg[0]))
        else $error("write to another page changed page zero");
endmodule : current_fault_response_ctrl

// ===== inc/fault_resp_pkg.sv
// shared constants for the current fault response controller
package fault_resp_pkg;

    // =====================================================================
    // command codes
    localparam logic [7:0] CODE_PAGE = 8'h00;
    localparam logic [7:0] CODE_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CODE_STATUS_IOUT = 8'h7B;
    localparam logic [7:0] CODE_OC_ACTION = 8'hE5;
    localparam logic [7:0] CODE_UC_ACTION = 8'hE6;

    // =====================================================================
    // fault action byte layout
    localparam logic [7:0] ACTION_RESET = 8'h80;
    localparam int RESP_MSB = 7;
    localparam int RESP_LSB = 6;
    localparam int RETRY_MSB = 5;
    localparam int RETRY_LSB = 3;
    localparam int DELAY_MSB = 2;
    localparam int DELAY_LSB = 0;
    localparam logic [1:0] RESP_SHUTDOWN = 2'h2;
    localparam logic [1:0] RESP_WHILE_FAULT = 2'h3;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;

    // =====================================================================
    // status byte layout
    localparam int STATUS_OC_BIT = 7;
    localparam int STATUS_UC_BIT = 4;

    // =====================================================================
    // timing
    localparam longint CLOCK_HZ = 64'd100_000_000;
    localparam longint RETRY_UNIT_MS = 64'd35;
    localparam int RETRY_UNIT_CYCLES = int'(CLOCK_HZ / 64'd1000 * RETRY_UNIT_MS);
    localparam int PAGES_DEFAULT = 2;
    localparam int SYNC_STAGES = 3;

    typedef enum logic [1:0] {
        ENG_RUN = 2'b00,
        ENG_LATCHED = 2'b01,
        ENG_RETRY = 2'b10,
        ENG_WHILE_FAULT = 2'b11
    } engine_state_e;

endpackage : fault_resp_pkg

// ===== core/fault_engine.sv
// response engine for one fault type on one output page
`timescale 1ns/10ps
module fault_engine (
    input wire logic clock, // system clock
    input wire logic srst, // synchronous reset, active high
    input wire logic tick, // one pulse per retry time unit
    input wire logic fault_level, // filtered fault level
    input wire logic [7:0] action, // fault action byte of this page
    input wire logic stop_retry, // commanded off, bias lost or other fault
    input wire logic clear_faults, // clear faults pulse
    output logic disable_reg, // output must stay off
    output logic restart_reg // start normal turn-on sequence
);
    fault_resp_pkg::engine_state_e state_reg, state_next;
    logic [3:0] count_reg;
    logic [1:0] resp;
    logic [2:0] retry;
    logic [3:0] interval;
    logic restart_next;

    assign resp = action[fault_resp_pkg::RESP_MSB:fault_resp_pkg::RESP_LSB];
    assign retry = action[fault_resp_pkg::RETRY_MSB:fault_resp_pkg::RETRY_LSB];
    assign interval = {1'b0, action[fault_resp_pkg::DELAY_MSB:fault_resp_pkg::DELAY_LSB]} + 4'h1;

    // =====================================================================
    // state sequence
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            fault_resp_pkg::ENG_RUN: begin
                if (fault_level) begin
                    if (resp == fault_resp_pkg::RESP_WHILE_FAULT) begin
                        state_next = fault_resp_pkg::ENG_WHILE_FAULT;
                    end else if (retry == fault_resp_pkg::RETRY_FOREVER && !stop_retry) begin
                        state_next = fault_resp_pkg::ENG_RETRY;
                    end else begin
                        state_next = fault_resp_pkg::ENG_LATCHED;
                    end
                end
            end
            fault_resp_pkg::ENG_LATCHED: begin
                if (clear_faults) begin
                    state_next = fault_resp_pkg::ENG_RUN;
                end
            end
            fault_resp_pkg::ENG_RETRY: begin
                if (stop_retry) begin
                    state_next = fault_resp_pkg::ENG_RUN;
                end else if (tick && count_reg == 4'h1) begin
                    state_next = fault_resp_pkg::ENG_RUN;
                end
            end
            fault_resp_pkg::ENG_WHILE_FAULT: begin
                if (!fault_level) begin
                    state_next = fault_resp_pkg::ENG_RUN;
                end
            end
        endcase
    end

    assign restart_next = state_reg != fault_resp_pkg::ENG_RUN && state_next == fault_resp_pkg::ENG_RUN
        && !stop_retry;

    always_ff @(posedge clock) begin
        if (srst) begin
            state_reg <= fault_resp_pkg::ENG_RUN;
            disable_reg <= 1'b0;
            restart_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            disable_reg <= state_next != fault_resp_pkg::ENG_RUN;
            restart_reg <= restart_next;
        end
    end

    // =====================================================================
    // retry spacing, counted from the start of each attempt
    always_ff @(posedge clock) begin
        if (srst || stop_retry) begin
            count_reg <= 4'h0;
        end else if (state_reg == fault_resp_pkg::ENG_RUN && state_next == fault_resp_pkg::ENG_RETRY
            && count_reg == 4'h0) begin
            count_reg <= interval;
        end else if (state_reg == fault_resp_pkg::ENG_RETRY && tick && count_reg == 4'h1) begin
            count_reg <= interval;
        end else if (tick && count_reg != 4'h0) begin
            count_reg <= count_reg - 4'h1;
        end
    end

    // =====================================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    chk_shutdown_immediate: assert property (state_reg == fault_resp_pkg::ENG_RUN && fault_level
        && resp == fault_resp_pkg::RESP_SHUTDOWN |=> disable_reg)
        else $error("shutdown response did not disable the output");
    chk_while_release: assert property (state_reg == fault_resp_pkg::ENG_WHILE_FAULT && !fault_level
        && !stop_retry |=> !disable_reg && restart_reg)
        else $error("output not re-enabled after fault went away");
    chk_no_retry_hold: assert property (state_reg == fault_resp_pkg::ENG_LATCHED && !clear_faults
        |=> disable_reg && !restart_reg)
        else $error("latched fault restarted without clear");
    chk_retry_reload: assert property (restart_reg && $past(state_reg) == fault_resp_pkg::ENG_RETRY
        |-> count_reg == interval)
        else $error("retry interval not restarted at the attempt");
    chk_stop_retry: assert property (stop_retry |=> state_reg != fault_resp_pkg::ENG_RETRY)
        else $error("retrying continued after stop");
endmodule : fault_engine

// ===== tb/cmd_host.sv
// command link host model for the fault response controller
`timescale 1ns/10ps
module cmd_host (
    input wire logic link_clock, // link clock
    input wire logic rsp_done, // command finished
    output logic cmd_start = 1'b0, // request pulse
    output logic cmd_write = 1'b0, // write flag
    output logic [7:0] cmd_code = 8'h00, // command code
    output logic [7:0] cmd_wdata = 8'h00 // write byte
);
    task xfer(input logic w, input logic [7:0] c, input logic [7:0] v, output logic ok);
        int k;
        @(posedge link_clock) #1 cmd_start = 1'b1;
        cmd_write = w;
        cmd_code = c;
        cmd_wdata = v;
        @(posedge link_clock) #1 cmd_start = 1'b0;
        // released lines must not keep the old value
        cmd_code = ~c;
        cmd_wdata = ~v;
        k = 0;
        while (rsp_done !== 1'b1 && k < 16) @(posedge link_clock) #1 k++;
        ok = k < 16;
    endtask : xfer
endmodule : cmd_host

// ===== tb/current_fault_response_ctrl_test.sv
// self-checking bench for the current fault response controller
`timescale 1ns/10ps
module current_fault_response_ctrl_test;
    logic clock = 0, link_clock = 0, srst = 1, link_srst = 1, aout, aoe, ok;
    logic cmd_start, cmd_write, cmd_busy, rsp_done, rsp_error;
    logic [7:0] cmd_code, cmd_wdata, rsp_rdata, d, r;
    logic [1:0] oc = 0, uc = 0, oe, ts;
    logic [15:0] st;
    logic [9:0] q[$];
    int err_count = 0, num_checks = 0, n;
    initial forever #5 clock = ~clock;
    initial forever #62.5 link_clock = ~link_clock;
    current_fault_response_ctrl #(.RETRY_UNIT_CYCLES(20)) uut (.clock, .srst, .link_clock, .link_srst,
        .cmd_start, .cmd_write, .cmd_code, .cmd_wdata, .cmd_busy, .rsp_done, .rsp_rdata, .rsp_error,
        .oc_fault_pin(oc), .uc_fault_pin(uc), .off_cmd(2'b00), .bias_ok(1'b1), .output_enable(oe),
        .turn_on_start(ts), .status_iout(st), .alert_pin_n_out(aout), .alert_pin_n_oe(aoe));
    cmd_host host (.link_clock, .rsp_done, .cmd_start, .cmd_write, .cmd_code, .cmd_wdata);
    task finish_test;
        if (err_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : finish_test
    task chk(input string s, input logic [7:0] x, input logic [7:0] g);
        num_checks++;
        if (g !== x) err_count++;
        if (g !== x) $display("ERROR %s expected %h seen %h", s, x, g);
    endtask : chk
    // note layout: error flag, data checked, data
    task cmd(input logic w, input logic [7:0] c, input logic [7:0] v, input logic [9:0] x);
        q.push_back(x);
        host.xfer(w, c, v, ok);
        if (!ok) err_count++;
        if (!ok) finish_test;
    endtask : cmd
    task wt(input int s, input logic v);
        n = 0;
        do @(posedge clock) #1 n++; while ((s == 2 ? ts[0] : oe[s]) !== v && n < 500);
        if (n >= 500) err_count++;
        if (n >= 500) finish_test;
    endtask : wt
    always @(negedge link_clock) if (rsp_done === 1'b1) begin
        chk("rsp_error", {7'h00, q[0][9]}, {7'h00, rsp_error});
        if (q[0][8]) chk("rsp_rdata", q[0][7:0], rsp_rdata);
        q.delete(0);
    end
    initial begin
        r = 8'($urandom(32'h8f4a));
        d = 8'($urandom % 8);
        repeat (6) @(posedge clock);
        repeat (2) @(posedge link_clock);
        #1 srst = 0;
        link_srst = 0;
        cmd(1, 8'hE6, r, 10'h000);
        cmd(0, 8'hE6, 8'h00, {2'b01, r});
        cmd(1, 8'h00, 8'h01, 10'h000);
        cmd(0, 8'hE6, 8'h00, 10'h180);
        cmd(0, 8'h55, 8'h00, 10'h200);
        @(posedge clock) #1 oc[0] = 1'b1;
        wt(0, 1'b0);
        chk("status_alert", 8'h82, {st[7:4], 2'b00, aoe, aout});
        oc[0] = 1'b0;
        #400 chk("latched", 8'h80, {st[7:1], oe[0]});
        cmd(1, 8'h03, 8'h00, 10'h000);
        wt(0, 1'b1);
        chk("cleared", 8'h00, {st[7:1], aoe});
        cmd(1, 8'hE6, 8'hC0, 10'h000);
        @(posedge clock) #1 uc[1] = 1'b1;
        wt(1, 1'b0);
        chk("status_iout", 8'h10, st[15:8]);
        uc[1] = 1'b0;
        wt(1, 1'b1);
        cmd(1, 8'h00, 8'h00, 10'h000);
        cmd(1, 8'hE5, 8'hB8 | d, 10'h000);
        @(posedge clock) #1 oc[0] = 1'b1;
        wt(2, 1'b1);
        wt(2, 1'b1);
        chk("retry_gap", 8'((d + 1) * 20), 8'(n));
        finish_test;
    end
endmodule : current_fault_response_ctrl_test
